// >>> core/status_flags_pkg.sv
// shared constants and carriers for the alarm, sticky flag and mask register group
package status_flags_pkg;

    localparam int ADDR_WIDTH = 8;
    localparam int DATA_WIDTH = 8;
    localparam int INPUT_COUNT = 2;

    // register offsets
    localparam logic [ADDR_WIDTH-1:0] OFFSET_TEMPERATURE_GRADE   = 8'h09;
    localparam logic [ADDR_WIDTH-1:0] OFFSET_PACKAGE_IDENTIFIER  = 8'h0a;
    localparam logic [ADDR_WIDTH-1:0] OFFSET_SERIAL_BUS_ADDRESS  = 8'h0b;
    localparam logic [ADDR_WIDTH-1:0] OFFSET_INTERNAL_STATUS     = 8'h0c;
    localparam logic [ADDR_WIDTH-1:0] OFFSET_INPUT_ALARM_LIVE    = 8'h0d;
    localparam logic [ADDR_WIDTH-1:0] OFFSET_LOOP_LIVE           = 8'h0e;
    localparam logic [ADDR_WIDTH-1:0] OFFSET_CALIBRATION_LIVE    = 8'h0f;
    localparam logic [ADDR_WIDTH-1:0] OFFSET_INTERNAL_STICKY     = 8'h11;
    localparam logic [ADDR_WIDTH-1:0] OFFSET_INPUT_ALARM_STICKY  = 8'h12;
    localparam logic [ADDR_WIDTH-1:0] OFFSET_LOOP_STICKY         = 8'h13;
    localparam logic [ADDR_WIDTH-1:0] OFFSET_CALIBRATION_STICKY  = 8'h14;
    localparam logic [ADDR_WIDTH-1:0] OFFSET_INTERNAL_MASKS      = 8'h17;
    localparam logic [ADDR_WIDTH-1:0] OFFSET_INPUT_ALARM_MASKS   = 8'h18;
    localparam logic [ADDR_WIDTH-1:0] OFFSET_LOOP_MASKS          = 8'h19;
    localparam logic [ADDR_WIDTH-1:0] OFFSET_CALIBRATION_MASKS   = 8'h1a;

    // field positions
    localparam int BIT_DEVICE_CALIBRATING  = 0;
    localparam int BIT_REFERENCE_LOST      = 1;
    localparam int BIT_SERIAL_TIMEOUT      = 5;
    localparam int BIT_SIGNAL_LOST_LOW     = 0;
    localparam int BIT_OFF_FREQUENCY_LOW   = 4;
    localparam int BIT_LOOP_UNLOCKED       = 1;
    localparam int BIT_LOOP_HOLDOVER       = 5;
    localparam int BIT_LOOP_CALIBRATING    = 5;
    localparam int BIT_UPPER_ADDRESS_LOW   = 2;
    localparam int BIT_UPPER_ADDRESS_HIGH  = 6;
    localparam int UPPER_ADDRESS_WIDTH     = 5;
    localparam int BUS_ADDRESS_WIDTH       = 7;

    // reset and read values
    localparam logic [DATA_WIDTH-1:0] RESET_MASKS      = 8'h00;
    localparam logic [DATA_WIDTH-1:0] READ_UNMAPPED    = 8'h00;
    localparam logic [UPPER_ADDRESS_WIDTH-1:0] RESET_UPPER_ADDRESS = 5'h1a;

    // live conditions from the detectors
    typedef struct packed {
        logic                   device_calibrating;
        logic                   reference_input_lost;
        logic                   serial_timeout;
        logic [INPUT_COUNT-1:0] input_signal_lost;
        logic [INPUT_COUNT-1:0] input_off_frequency;
        logic                   loop_unlocked;
        logic                   loop_holdover;
        logic                   loop_calibrating;
    } status_live_t;

    // one register access from the serial port engine
    typedef struct packed {
        logic                  write;
        logic                  read;
        logic [ADDR_WIDTH-1:0] addr;
        logic [DATA_WIDTH-1:0] wdata;
    } reg_request_t;

    typedef struct packed {
        logic                  valid;
        logic [DATA_WIDTH-1:0] rdata;
    } reg_answer_t;

endpackage

// >>> core/clock_alarm_status_flags.sv
// live alarms, sticky flags, interrupt masks and bus address register group
//
// Contract
// - upper five address bits from register bits 6:2
// - two lower address bits from select pins
// - internal status bit 0 shows calibrating
// - internal status bit 1 shows reference lost
// - internal status bit 5 shows serial timeout
// - live loss of signal in bits 1:0
// - live off frequency in bits 5:4
// - input zero bits 0/4, one 1/5
// - live input alarms follow condition, no latch
// - loop status bit 1 shows unlocked, live
// - loop status bit 5 shows holdover, live
// - calibration status bit 5 shows busy, live
// - sticky internal flags, cleared by writing zero
// - sticky input alarms, cleared by writing zero
// - sticky unlock and holdover, cleared by zero
// - sticky loop calibration flag, bit 5
// - internal flag masks at bits 0,1,5
// - unmasked reference loss flag drives interrupt
// - per input masks at 1:0 and 5:4
// - unlock and holdover masks at 1 and 5
// - loop calibration mask at bit 5
`timescale 1ns/1ns

module clock_alarm_status_flags #(
    // arbitrary value
    parameter logic [7:0] TEMPERATURE_GRADE_VALUE = 8'h00,
    // arbitrary value
    parameter logic [7:0] PACKAGE_IDENTIFIER_VALUE = 8'h0f
) (
    // clock and reset
    input  wire logic                                        sys_clk,
    input  wire logic                                        rst,
    // detector conditions
    input  wire status_flags_pkg::status_live_t              live_in,
    // address select pins
    input  wire logic                                        address_select_high_pin,
    input  wire logic                                        address_select_low_pin,
    // register port from the serial engine
    input  wire status_flags_pkg::reg_request_t              reg_request,
    output status_flags_pkg::reg_answer_t                    reg_answer,
    // formed serial bus address
    output logic [status_flags_pkg::BUS_ADDRESS_WIDTH-1:0]   device_bus_address,
    // interrupt
    output logic                                             interrupt_out_n
);
    import status_flags_pkg::*;

    // sticky update: set wins over a written zero, writing one leaves it alone
    function automatic logic sticky_next(input logic flag,
                                         input logic cond,
                                         input logic wr,
                                         input logic wbit);
        logic keep;

        keep = flag & (~wr | wbit);
        return keep | cond;
    endfunction

    function automatic logic hits(input logic [ADDR_WIDTH-1:0] offset);
        return reg_request.addr == offset;
    endfunction

    // live copies
    logic                   device_calibrating;
    logic                   reference_input_lost;
    logic                   serial_timeout;
    logic [INPUT_COUNT-1:0] input_signal_lost;
    logic [INPUT_COUNT-1:0] input_off_frequency;
    logic                   loop_unlocked;
    logic                   loop_holdover;
    logic                   loop_calibrating;

    // sticky copies
    logic                   device_calibrating_sticky;
    logic                   reference_input_lost_sticky;
    logic                   serial_timeout_sticky;
    logic [INPUT_COUNT-1:0] input_signal_lost_sticky;
    logic [INPUT_COUNT-1:0] input_off_frequency_sticky;
    logic                   loop_unlocked_sticky;
    logic                   loop_holdover_sticky;
    logic                   loop_calibration_sticky;

    // masks
    logic                   device_calibrating_mask;
    logic                   reference_input_lost_mask;
    logic                   serial_timeout_mask;
    logic [INPUT_COUNT-1:0] input_signal_lost_mask;
    logic [INPUT_COUNT-1:0] input_off_frequency_mask;
    logic                   loop_unlocked_mask;
    logic                   loop_holdover_mask;
    logic                   loop_calibration_mask;

    logic [UPPER_ADDRESS_WIDTH-1:0] upper_address;

    logic wr_internal_sticky;
    logic wr_input_sticky;
    logic wr_loop_sticky;
    logic wr_calibration_sticky;

    logic wr_internal_masks;
    logic wr_input_masks;
    logic wr_loop_masks;
    logic wr_calibration_masks;
    logic wr_bus_address;

    logic [DATA_WIDTH-1:0] next_rdata;
    logic                  next_interrupt_out_n;

    // write decodes
    assign wr_internal_sticky    = reg_request.write && hits(OFFSET_INTERNAL_STICKY);
    assign wr_input_sticky       = reg_request.write && hits(OFFSET_INPUT_ALARM_STICKY);
    assign wr_loop_sticky        = reg_request.write && hits(OFFSET_LOOP_STICKY);
    assign wr_calibration_sticky = reg_request.write && hits(OFFSET_CALIBRATION_STICKY);

    assign wr_internal_masks     = reg_request.write && hits(OFFSET_INTERNAL_MASKS);
    assign wr_input_masks        = reg_request.write && hits(OFFSET_INPUT_ALARM_MASKS);
    assign wr_loop_masks         = reg_request.write && hits(OFFSET_LOOP_MASKS);
    assign wr_calibration_masks  = reg_request.write && hits(OFFSET_CALIBRATION_MASKS);
    assign wr_bus_address        = reg_request.write && hits(OFFSET_SERIAL_BUS_ADDRESS);

    // live status follows the detectors with one register stage, never latching
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            device_calibrating   <= 1'b0;
            reference_input_lost <= 1'b0;
            serial_timeout       <= 1'b0;
            input_signal_lost    <= '0;
            input_off_frequency  <= '0;
            loop_unlocked        <= 1'b0;
            loop_holdover        <= 1'b0;
            loop_calibrating     <= 1'b0;
        end else begin
            device_calibrating   <= live_in.device_calibrating;
            reference_input_lost <= live_in.reference_input_lost;
            serial_timeout       <= live_in.serial_timeout;
            input_signal_lost    <= live_in.input_signal_lost;
            input_off_frequency  <= live_in.input_off_frequency;
            loop_unlocked        <= live_in.loop_unlocked;
            loop_holdover        <= live_in.loop_holdover;
            loop_calibrating     <= live_in.loop_calibrating;
        end
    end

    // sticky internal status flags
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            device_calibrating_sticky   <= 1'b0;
            reference_input_lost_sticky <= 1'b0;
            serial_timeout_sticky       <= 1'b0;
        end else begin
            device_calibrating_sticky <= sticky_next(device_calibrating_sticky,
                device_calibrating, wr_internal_sticky,
                reg_request.wdata[BIT_DEVICE_CALIBRATING]);
            reference_input_lost_sticky <= sticky_next(reference_input_lost_sticky,
                reference_input_lost, wr_internal_sticky,
                reg_request.wdata[BIT_REFERENCE_LOST]);
            serial_timeout_sticky <= sticky_next(serial_timeout_sticky,
                serial_timeout, wr_internal_sticky,
                reg_request.wdata[BIT_SERIAL_TIMEOUT]);
        end
    end

    // sticky per-input alarms and their masks
    genvar gi;
    generate
        for (gi = 0; gi < INPUT_COUNT; gi++) begin : g_input
            always_ff @(posedge sys_clk or posedge rst) begin
                if (rst) begin
                    input_signal_lost_sticky[gi]   <= 1'b0;
                    input_off_frequency_sticky[gi] <= 1'b0;
                end else begin
                    input_signal_lost_sticky[gi] <= sticky_next(
                        input_signal_lost_sticky[gi], input_signal_lost[gi],
                        wr_input_sticky,
                        reg_request.wdata[BIT_SIGNAL_LOST_LOW + gi]);
                    input_off_frequency_sticky[gi] <= sticky_next(
                        input_off_frequency_sticky[gi], input_off_frequency[gi],
                        wr_input_sticky,
                        reg_request.wdata[BIT_OFF_FREQUENCY_LOW + gi]);
                end
            end

            always_ff @(posedge sys_clk or posedge rst) begin
                if (rst) begin
                    input_signal_lost_mask[gi]   <= RESET_MASKS[BIT_SIGNAL_LOST_LOW + gi];
                    input_off_frequency_mask[gi] <= RESET_MASKS[BIT_OFF_FREQUENCY_LOW + gi];
                end else if (wr_input_masks) begin
                    input_signal_lost_mask[gi]   <=
                        reg_request.wdata[BIT_SIGNAL_LOST_LOW + gi];
                    input_off_frequency_mask[gi] <=
                        reg_request.wdata[BIT_OFF_FREQUENCY_LOW + gi];
                end
            end
        end
    endgenerate

    // sticky loop flags
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            loop_unlocked_sticky    <= 1'b0;
            loop_holdover_sticky    <= 1'b0;
            loop_calibration_sticky <= 1'b0;
        end else begin
            loop_unlocked_sticky <= sticky_next(loop_unlocked_sticky,
                loop_unlocked, wr_loop_sticky,
                reg_request.wdata[BIT_LOOP_UNLOCKED]);
            loop_holdover_sticky <= sticky_next(loop_holdover_sticky,
                loop_holdover, wr_loop_sticky,
                reg_request.wdata[BIT_LOOP_HOLDOVER]);

            loop_calibration_sticky <= sticky_next(loop_calibration_sticky,
                loop_calibrating, wr_calibration_sticky,
                reg_request.wdata[BIT_LOOP_CALIBRATING]);
        end
    end

    // internal and loop masks
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            device_calibrating_mask   <= RESET_MASKS[BIT_DEVICE_CALIBRATING];
            reference_input_lost_mask <= RESET_MASKS[BIT_REFERENCE_LOST];
            serial_timeout_mask       <= RESET_MASKS[BIT_SERIAL_TIMEOUT];
            loop_unlocked_mask        <= RESET_MASKS[BIT_LOOP_UNLOCKED];
            loop_holdover_mask        <= RESET_MASKS[BIT_LOOP_HOLDOVER];
            loop_calibration_mask     <= RESET_MASKS[BIT_LOOP_CALIBRATING];
        end else begin
            if (wr_internal_masks) begin
                device_calibrating_mask   <= reg_request.wdata[BIT_DEVICE_CALIBRATING];
                reference_input_lost_mask <= reg_request.wdata[BIT_REFERENCE_LOST];
                serial_timeout_mask       <= reg_request.wdata[BIT_SERIAL_TIMEOUT];
            end

            if (wr_loop_masks) begin
                loop_unlocked_mask <= reg_request.wdata[BIT_LOOP_UNLOCKED];
                loop_holdover_mask <= reg_request.wdata[BIT_LOOP_HOLDOVER];
            end

            if (wr_calibration_masks) begin
                loop_calibration_mask <= reg_request.wdata[BIT_LOOP_CALIBRATING];
            end
        end
    end

    // programmable upper address bits
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            upper_address <= RESET_UPPER_ADDRESS;
        end else if (wr_bus_address) begin
            upper_address <= reg_request.wdata[BIT_UPPER_ADDRESS_HIGH:BIT_UPPER_ADDRESS_LOW];
        end
    end

    // pins join the stored bits in one flop
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            device_bus_address <= '0;
        end else begin
            device_bus_address <= {upper_address,
                                   address_select_high_pin,
                                   address_select_low_pin};
        end
    end

    // interrupt: low while any unmasked sticky flag stands
    always_comb begin
        next_interrupt_out_n = 1'b1;
        if ((device_calibrating_sticky   && !device_calibrating_mask)   ||
            (reference_input_lost_sticky && !reference_input_lost_mask) ||
            (serial_timeout_sticky       && !serial_timeout_mask)       ||
            |(input_signal_lost_sticky   & ~input_signal_lost_mask)     ||
            |(input_off_frequency_sticky & ~input_off_frequency_mask)   ||
            (loop_unlocked_sticky        && !loop_unlocked_mask)        ||
            (loop_holdover_sticky        && !loop_holdover_mask)        ||
            (loop_calibration_sticky     && !loop_calibration_mask)) begin
            next_interrupt_out_n = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            interrupt_out_n <= 1'b1;
        end else begin
            interrupt_out_n <= next_interrupt_out_n;
        end
    end

    // read multiplexer
    always_comb begin
        // unused bits read as zero
        next_rdata = READ_UNMAPPED;
        case (reg_request.addr)
            OFFSET_TEMPERATURE_GRADE: begin
                next_rdata = TEMPERATURE_GRADE_VALUE;
            end
            OFFSET_PACKAGE_IDENTIFIER: begin
                next_rdata = PACKAGE_IDENTIFIER_VALUE;
            end
            OFFSET_SERIAL_BUS_ADDRESS: begin
                next_rdata[BIT_UPPER_ADDRESS_HIGH:BIT_UPPER_ADDRESS_LOW] = upper_address;
            end

            OFFSET_INTERNAL_STATUS: begin
                next_rdata[BIT_DEVICE_CALIBRATING] = device_calibrating;
                next_rdata[BIT_REFERENCE_LOST]     = reference_input_lost;
                next_rdata[BIT_SERIAL_TIMEOUT]     = serial_timeout;
            end
            OFFSET_INPUT_ALARM_LIVE: begin
                next_rdata[BIT_SIGNAL_LOST_LOW +: INPUT_COUNT]   = input_signal_lost;
                next_rdata[BIT_OFF_FREQUENCY_LOW +: INPUT_COUNT] = input_off_frequency;
            end
            OFFSET_LOOP_LIVE: begin
                next_rdata[BIT_LOOP_UNLOCKED] = loop_unlocked;
                next_rdata[BIT_LOOP_HOLDOVER] = loop_holdover;
            end
            OFFSET_CALIBRATION_LIVE: begin
                next_rdata[BIT_LOOP_CALIBRATING] = loop_calibrating;
            end

            OFFSET_INTERNAL_STICKY: begin
                next_rdata[BIT_DEVICE_CALIBRATING] = device_calibrating_sticky;
                next_rdata[BIT_REFERENCE_LOST]     = reference_input_lost_sticky;
                next_rdata[BIT_SERIAL_TIMEOUT]     = serial_timeout_sticky;
            end
            OFFSET_INPUT_ALARM_STICKY: begin
                next_rdata[BIT_SIGNAL_LOST_LOW +: INPUT_COUNT]   = input_signal_lost_sticky;
                next_rdata[BIT_OFF_FREQUENCY_LOW +: INPUT_COUNT] = input_off_frequency_sticky;
            end
            OFFSET_LOOP_STICKY: begin
                next_rdata[BIT_LOOP_UNLOCKED] = loop_unlocked_sticky;
                next_rdata[BIT_LOOP_HOLDOVER] = loop_holdover_sticky;
            end
            OFFSET_CALIBRATION_STICKY: begin
                next_rdata[BIT_LOOP_CALIBRATING] = loop_calibration_sticky;
            end

            OFFSET_INTERNAL_MASKS: begin
                next_rdata[BIT_DEVICE_CALIBRATING] = device_calibrating_mask;
                next_rdata[BIT_REFERENCE_LOST]     = reference_input_lost_mask;
                next_rdata[BIT_SERIAL_TIMEOUT]     = serial_timeout_mask;
            end
            OFFSET_INPUT_ALARM_MASKS: begin
                next_rdata[BIT_SIGNAL_LOST_LOW +: INPUT_COUNT]   = input_signal_lost_mask;
                next_rdata[BIT_OFF_FREQUENCY_LOW +: INPUT_COUNT] = input_off_frequency_mask;
            end
            OFFSET_LOOP_MASKS: begin
                next_rdata[BIT_LOOP_UNLOCKED] = loop_unlocked_mask;
                next_rdata[BIT_LOOP_HOLDOVER] = loop_holdover_mask;
            end
            OFFSET_CALIBRATION_MASKS: begin
                next_rdata[BIT_LOOP_CALIBRATING] = loop_calibration_mask;
            end

            default: begin
                next_rdata = READ_UNMAPPED;
            end
        endcase
    end

    // answer stands one cycle after the read request
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reg_answer <= '0;
        end else begin
            reg_answer.valid <= reg_request.read;
            reg_answer.rdata <= reg_request.read ? next_rdata : READ_UNMAPPED;
        end
    end

endmodule // clock_alarm_status_flags

// >>> testbench/clock_alarm_status_flags_asserts.sv
// port-level assertions for the alarm, sticky flag and mask register group
`timescale 1ns/1ns
module clock_alarm_status_flags_asserts
    import status_flags_pkg::*;
(
    // clock and reset
    input wire logic                           sys_clk,
    input wire logic                           rst,
    // watched ports
    input wire status_flags_pkg::status_live_t live_in,
    input wire logic                           address_select_high_pin,
    input wire logic                           address_select_low_pin,
    input wire status_flags_pkg::reg_request_t reg_request,
    input wire status_flags_pkg::reg_answer_t  reg_answer,
    input wire logic [6:0]                     device_bus_address,
    input wire logic                           interrupt_out_n
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    wire logic       rd = reg_request.read;
    wire logic [7:0] ra = reg_request.addr;
    wire logic [7:0] q  = reg_answer.rdata;

    chk_read_answer: assert property (rd |=> reg_answer.valid) else $error("read not answered");
    chk_no_stray: assert property (!rd |=> !reg_answer.valid && q == 8'h00)
        else $error("stray read answer");
    chk_pin_bits: assert property (1'b1 |=> device_bus_address[1:0] ==
        {$past(address_select_high_pin), $past(address_select_low_pin)}) else $error("pin bits");
    chk_upper_write: assert property (!$past(rst, 2) && !$past(rst)
        && $changed(device_bus_address[6:2]) |-> $past(reg_request.write, 2)
        && $past(ra, 2) == 8'h0b) else $error("upper address moved");
    chk_live_internal: assert property (rd && ra == 8'h0c |=> q == {2'b00,
        $past(live_in.serial_timeout, 2), 3'b000, $past(live_in.reference_input_lost, 2),
        $past(live_in.device_calibrating, 2)}) else $error("internal status read");
    chk_live_input: assert property (rd && ra == 8'h0d |=> q == {2'b00,
        $past(live_in.input_off_frequency, 2), 2'b00, $past(live_in.input_signal_lost, 2)})
        else $error("input alarm read");
    chk_live_loop: assert property (rd && ra == 8'h0e |=> q == {2'b00,
        $past(live_in.loop_holdover, 2), 3'b000, $past(live_in.loop_unlocked, 2), 1'b0})
        else $error("loop status read");
    chk_unmapped_read: assert property (rd && (ra == 8'h10 || ra > 8'h1a) |=> q == 8'h00)
        else $error("unmapped read");
    chk_irq_fall: assert property ($fell(interrupt_out_n) |-> $past(live_in, 3) != '0
        || $past(live_in, 4) != '0 || $past(reg_request.write, 2)) else $error("irq fell");
    chk_irq_rise: assert property ($rose(interrupt_out_n) |-> $past(reg_request.write, 2))
        else $error("irq rose");
endmodule // clock_alarm_status_flags_asserts

bind clock_alarm_status_flags clock_alarm_status_flags_asserts chk (.sys_clk(sys_clk),
    .rst(rst), .live_in(live_in), .address_select_high_pin(address_select_high_pin),
    .address_select_low_pin(address_select_low_pin), .reg_request(reg_request),
    .reg_answer(reg_answer), .device_bus_address(device_bus_address),
    .interrupt_out_n(interrupt_out_n));

// >>> testbench/serial_host_model.sv
// host processor model issuing register accesses on the strobe port
`timescale 1ns/1ns
module serial_host_model
    import status_flags_pkg::*;
(
    // clock
    input wire logic                           sys_clk,
    // register port
    output status_flags_pkg::reg_request_t     reg_request,
    input wire status_flags_pkg::reg_answer_t  reg_answer
);
    initial reg_request = '0;
    // a gap of idle edges first, so a strobe is never driven twice in one step
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d, input int gap);
        repeat (gap + 1) @(posedge sys_clk);
        reg_request <= '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
        @(posedge sys_clk);
        reg_request <= '0;
    endtask
    task automatic read_reg(input logic [7:0] a, input int gap, output logic [7:0] d,
                            output bit ok);
        ok = 0;
        d = 'x;
        repeat (gap + 1) @(posedge sys_clk);
        reg_request <= '{write: 1'b0, read: 1'b1, addr: a, wdata: 8'h00};
        @(posedge sys_clk);
        reg_request <= '0;
        for (int i = 0; i < 4 && !ok; i++) begin
            @(posedge sys_clk);
            ok = (reg_answer.valid === 1'b1);
            d = reg_answer.rdata;
        end
    endtask
endmodule // serial_host_model

// >>> testbench/clock_alarm_status_flags_tb.sv
// self-checking bench for the alarm, sticky flag and mask register group
`timescale 1ns/1ns
`define CHECK(w, e, g) begin n_compared++; if ((g) !== (e)) begin failures++; $display("mismatch %s expected %h seen %h", w, e, g); end end
module clock_alarm_status_flags_tb;
    import status_flags_pkg::*;
    localparam logic [7:0] PKG_VALUE = 8'h3c; // arbitrary value
    logic         sys_clk = 1'b0;
    logic         rst = 1'b1;
    logic         pin_hi = 1'b0;
    logic         pin_lo = 1'b0;
    logic [6:0]   dba;
    logic         irq_n;
    status_live_t live_in = '0;
    status_live_t cur;
    reg_request_t reg_request;
    reg_answer_t  reg_answer;
    logic [7:0]   sticky [4];
    logic [7:0]   got;
    logic [7:0]   wd;
    bit           ok;
    int           failures = 0;
    int           n_compared = 0;

    always #25 sys_clk = ~sys_clk;

    clock_alarm_status_flags #(.PACKAGE_IDENTIFIER_VALUE(PKG_VALUE)) dut (.sys_clk(sys_clk),
        .rst(rst), .live_in(live_in), .address_select_high_pin(pin_hi),
        .address_select_low_pin(pin_lo), .reg_request(reg_request), .reg_answer(reg_answer),
        .device_bus_address(dba), .interrupt_out_n(irq_n));
    serial_host_model host (.sys_clk(sys_clk), .reg_request(reg_request),
        .reg_answer(reg_answer));

    // register byte seen for a live condition set, k selects 0x0c..0x0f
    function automatic logic [7:0] view(status_live_t s, int k);
        case (k)
            0: return {2'b00, s.serial_timeout, 3'b000, s.reference_input_lost,
                       s.device_calibrating};
            1: return {2'b00, s.input_off_frequency, 2'b00, s.input_signal_lost};
            2: return {2'b00, s.loop_holdover, 3'b000, s.loop_unlocked, 1'b0};
            default: return {2'b00, s.loop_calibrating, 5'b00000};
        endcase
    endfunction
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic expect_reg(input logic [7:0] a, input logic [7:0] e);
        host.read_reg(a, $urandom_range(2), got, ok);
        if (!ok) begin
            failures++;
            close_out();
        end else
        `CHECK($sformatf("reg %h", a), e, got)
    endtask

    initial begin
        void'($urandom(32'h5cbfa2d9));
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            sticky[k] = 8'h00;
            expect_reg(8'(8'h17 + k), RESET_MASKS);
        end
        expect_reg(OFFSET_PACKAGE_IDENTIFIER, PKG_VALUE);
        expect_reg(OFFSET_TEMPERATURE_GRADE, 8'h00);
        expect_reg(OFFSET_SERIAL_BUS_ADDRESS, {1'b0, RESET_UPPER_ADDRESS, 2'b00});
        repeat (3) begin
            wd = 8'($urandom);
            pin_hi <= 1'($urandom);
            pin_lo <= 1'($urandom);
            host.write_reg(OFFSET_SERIAL_BUS_ADDRESS, wd, 1);
            host.write_reg(8'h10, 8'hff, 0);
            host.write_reg(OFFSET_INTERNAL_STATUS, 8'hff, 0);
            expect_reg(8'h10, READ_UNMAPPED);
            expect_reg(OFFSET_SERIAL_BUS_ADDRESS, {1'b0, wd[6:2], 2'b00});
            `CHECK("bus address", {wd[6:2], pin_hi, pin_lo}, dba)
        end
        // random live alarms, then sticky reads with random clearing writes
        for (int n = 0; n < 24; n++) begin
            cur = (n % 3 == 2) ? '0 : status_live_t'(10'($urandom));
            live_in <= cur;
            repeat (3) @(posedge sys_clk);
            for (int k = 0; k < 4; k++) begin
                sticky[k] = sticky[k] | view(cur, k);
                expect_reg(8'(8'h0c + k), view(cur, k));
                if (n % 4 == 3) begin
                    wd = 8'($urandom);
                    host.write_reg(8'(8'h11 + k), wd, 0);
                    sticky[k] = (sticky[k] & wd) | view(cur, k);
                end
                expect_reg(8'(8'h11 + k), sticky[k]);
            end
            `CHECK("interrupt", ~|{sticky[0], sticky[1], sticky[2], sticky[3]}, irq_n)
        end
        // masks block the interrupt, reference loss alone unmasked drives it
        cur = '0;
        cur.reference_input_lost = 1'b1;
        live_in <= cur;
        sticky[0] = sticky[0] | 8'h02;
        for (int k = 0; k < 4; k++) begin
            host.write_reg(8'(8'h17 + k), 8'hff, 0);
            expect_reg(8'(8'h17 + k), view('1, k));
        end
        `CHECK("interrupt", 1'b1, irq_n)
        host.write_reg(OFFSET_INTERNAL_MASKS, 8'h21, 0);
        expect_reg(OFFSET_INTERNAL_STICKY, sticky[0]);
        `CHECK("interrupt", 1'b0, irq_n)
        live_in <= '0;
        repeat (3) @(posedge sys_clk);
        for (int k = 0; k < 4; k++) begin
            host.write_reg(8'(8'h11 + k), 8'h00, 0);
            host.write_reg(8'(8'h17 + k), 8'h00, 0);
            expect_reg(8'(8'h11 + k), 8'h00);
        end
        `CHECK("interrupt", 1'b1, irq_n)
        close_out();
    end
endmodule // clock_alarm_status_flags_tb
